//--- core/pscd_defines.svh
// Constants for the pump serial command decoder
`ifndef PSCD_DEFINES_SVH
`define PSCD_DEFINES_SVH

// ----------------------------------------------------------------
// Characters
// ----------------------------------------------------------------
`define PSCD_CH_CR 8'h0d
`define PSCD_CH_COMMA 8'h2c
`define PSCD_CH_ZERO 8'h30
`define PSCD_CH_NINE 8'h39
`define PSCD_CH_ERR 8'h3f
`define PSCD_CH_A 8'h61
`define PSCD_CH_B 8'h62
`define PSCD_CH_C 8'h63
`define PSCD_CH_E 8'h65
`define PSCD_CH_F 8'h66
`define PSCD_CH_G 8'h67

// ----------------------------------------------------------------
// Operation control word bit positions
// ----------------------------------------------------------------
`define PSCD_BIT_STOP 1
`define PSCD_BIT_PROD 2
`define PSCD_BIT_FLUID 3
`define PSCD_BIT_REF 4
`define PSCD_BIT_CLR_FAULT 5
`define PSCD_BIT_CLR_ALERT 6
`define PSCD_BIT_REF_UNSTICK 11
`define PSCD_BIT_REF_TORQUE 12
`define PSCD_BIT_NEXT_OP 13

// ----------------------------------------------------------------
// Highest index per command letter, response codes, resets, converter shift count
// ----------------------------------------------------------------
`define PSCD_MAX_A 32'd3
`define PSCD_MAX_B 32'd1
`define PSCD_MAX_C 32'd2
`define PSCD_MAX_F 32'd2
`define PSCD_MAX_G 32'd6
`define PSCD_MAX_G_CLR 32'd4
`define PSCD_WARN_SECOND_CMD 32'h00000001
`define PSCD_ERR_BAD_CMD 32'h00000002
`define PSCD_PARAM_RST 16'h0000
`define PSCD_CONV_BITS 6'h20

`endif

//--- core/pscd_pkg.sv
// Types for the pump serial command decoder
package pscd_pkg;

	// Command and response sequencing states
	typedef enum logic [10:0] {
		ST_RECV = 11'h001,
		ST_EXEC = 11'h002,
		ST_SETTLE = 11'h004,
		ST_SAMPLE = 11'h008,
		ST_SEND_CMD = 11'h010,
		ST_SEND_V1 = 11'h020,
		ST_SEND_SEP1 = 11'h040,
		ST_SEND_V2 = 11'h080,
		ST_SEND_SEP2 = 11'h100,
		ST_SEND_V3 = 11'h200,
		ST_SEND_CR = 11'h400
	} pscd_state_type;

	// Decimal converter states
	typedef enum logic [2:0] {
		CV_IDLE = 3'h1,
		CV_SHIFT = 3'h2,
		CV_EMIT = 3'h4
	} pscd_conv_type;

endpackage

//--- core/pscd_dec_conv.sv
// Binary to decimal ASCII converter, emits digits most significant first
`timescale 1ns/1ps
`include "pscd_defines.svh"

module pscd_dec_conv
	import pscd_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_start,
	input wire logic [31:0] i_value,
	input wire logic i_take,
	output logic o_valid,
	output logic [7:0] o_char,
	output logic o_last
);

	pscd_conv_type state_reg, state_next;
	logic [31:0] bin_reg, bin_next;
	logic [39:0] bcd_reg, bcd_next;
	logic [39:0] bcd_adj;
	logic [5:0] cnt_reg, cnt_next;
	logic [3:0] idx_reg, idx_next;
	logic started_reg, started_next;
	logic [3:0] digit;

	// Add three to every BCD digit of five or more before each shift
	genvar g;
	generate
		for (g = 0; g < 10; g = g + 1) begin : g_adj
			assign bcd_adj[g*4 +: 4] = (bcd_reg[g*4 +: 4] >= 4'h5) ?
				bcd_reg[g*4 +: 4] + 4'h3 : bcd_reg[g*4 +: 4];
		end
	endgenerate

	// Leading zeros are skipped, a lone zero is still sent
	assign digit = bcd_reg[idx_reg*4 +: 4];
	assign o_valid = (state_reg == CV_EMIT) && (digit != 4'h0 || idx_reg == 4'h0 || started_reg);
	assign o_char = `PSCD_CH_ZERO | {4'h0, digit};
	assign o_last = (idx_reg == 4'h0);

	// Next state of the converter
	always_comb begin
		state_next = state_reg;
		bin_next = bin_reg;
		bcd_next = bcd_reg;
		cnt_next = cnt_reg;
		idx_next = idx_reg;
		started_next = started_reg;
		case (state_reg)
			CV_IDLE: begin
				if (i_start) begin
					bin_next = i_value;
					bcd_next = 40'h0;
					cnt_next = `PSCD_CONV_BITS;
					state_next = CV_SHIFT;
				end
			end
			CV_SHIFT: begin
				bcd_next = {bcd_adj[38:0], bin_reg[31]};
				bin_next = {bin_reg[30:0], 1'b0};
				cnt_next = cnt_reg - 6'h1;
				if (cnt_reg == 6'h1) begin
					idx_next = 4'h9;
					started_next = 1'b0;
					state_next = CV_EMIT;
				end
			end
			CV_EMIT: begin
				if (!o_valid) begin
					idx_next = idx_reg - 4'h1;
				end else if (i_take) begin
					started_next = 1'b1;
					if (idx_reg == 4'h0) begin
						state_next = CV_IDLE;
					end else begin
						idx_next = idx_reg - 4'h1;
					end
				end
			end
			default: begin
				state_next = CV_IDLE;
			end
		endcase
	end

	// Converter registers
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= CV_IDLE;
			bin_reg <= 32'h0;
			bcd_reg <= 40'h0;
			cnt_reg <= 6'h0;
			idx_reg <= 4'h0;
			started_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bin_reg <= bin_next;
			bcd_reg <= bcd_next;
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
			started_reg <= started_next;
		end
	end

endmodule // pscd_dec_conv

//--- core/pscd_decoder.sv
// Serial command decoder: parses command bytes, acts, sends the response
// Function
// - a0 reads load mode, writes it when a second argument is given.
// - a1 reads chamber mode, writes it with a second argument.
// - a2 reads autotrigger mode, writes it with a second argument.
// - a3 reads autotrigger count, writes it with a second argument.
// - b or b0 sets control bit 2, production start.
// - b1 sets control bit 3, fluidic setup start.
// - c or c0 sets control bit 5, clear fault.
// - c1 sets control bit 6, clear alert.
// - c2 sets control bit 13, start next required operation.
// - e or e0 sets control bit 1, stop pumping.
// - Stop in prime mode ends only once piston reaches stop position.
// - Stop in agitate mode ends only once fluid is back at start.
// - f or f0 sets control bit 4, reference.
// - f1 sets control bit 11, reference with unstick.
// - f2 sets control bit 12, reference with torque test.
// - g0 reads total production volume; g0,0 clears it.
// - g1 reads total production cycles; g1,0 clears them.
// - g2 reads last fluidic volume; g2,0 clears it.
// - g3 reads last production volume; g3,0 clears it.
// - g4 reads total fluidic cycles; g4,0 clears them.
// - g5 reads total reference cycles.
// - g6 reads total load cycles.
// - Command is letter, optional value, optional comma value, ended by CR.
// - Response echoes command and values, then fault or warning code.
// - First letter is the command; a later letter voids it with warning.
`timescale 1ns/1ps
`include "pscd_defines.svh"

module pscd_decoder
	import pscd_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	output logic o_rx_ready,
	output logic o_tx_valid,
	output logic [7:0] o_tx_data,
	input wire logic i_tx_ready,
	output logic [15:0] o_op_ctrl,
	input wire logic [15:0] i_op_ack,
	output logic o_op_end,
	input wire logic i_prime_mode,
	input wire logic i_agitate_mode,
	input wire logic i_piston_at_stop,
	input wire logic i_fluid_at_start,
	input wire logic [15:0] i_status_code,
	output logic [15:0] o_load_mode,
	output logic [15:0] o_chamber_mode,
	output logic [15:0] o_autotrig_mode,
	output logic [15:0] o_autotrig_count,
	output logic [4:0] o_total_clr,
	input wire logic [31:0] i_total_prod_vol,
	input wire logic [31:0] i_total_prod_cyc,
	input wire logic [31:0] i_last_fluid_vol,
	input wire logic [31:0] i_last_prod_vol,
	input wire logic [31:0] i_total_fluid_cyc,
	input wire logic [31:0] i_total_ref_cyc,
	input wire logic [31:0] i_total_load_cyc
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pscd_state_type state_reg, state_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [31:0] v1_reg, v1_next, v2_reg, v2_next;
	logic [31:0] resp_reg, resp_next, code_reg, code_next;
	logic have_cmd_reg, have_cmd_next, comma_reg, comma_next;
	logic v2_seen_reg, v2_seen_next, alpha2_reg, alpha2_next, bad_reg, bad_next;
	logic empty_reg, empty_next, err_reg, err_next;
	logic rx_ready_reg, rx_ready_next, tx_valid_reg, tx_valid_next;
	logic [7:0] tx_data_reg, tx_data_next;
	logic [15:0] param_reg [0:3];
	logic [15:0] param_next [0:3];
	logic [4:0] clr_reg, clr_next;
	logic [15:0] op_reg, op_next, op_set;
	logic stop_pend_reg, stop_pend_next, op_end_reg, op_end_next, stop_ok;
	logic rx_take, can_load, is_alpha, is_digit, cmd_ok;
	logic conv_start, conv_valid, conv_last, conv_take;
	logic [31:0] conv_value, tot_value;
	logic [7:0] conv_char;

	assign rx_take = i_rx_valid && rx_ready_reg;
	assign can_load = !tx_valid_reg || i_tx_ready;
	assign is_alpha = (i_rx_data >= 8'h41 && i_rx_data <= 8'h5a) ||
		(i_rx_data >= 8'h61 && i_rx_data <= 8'h7a);
	assign is_digit = (i_rx_data >= `PSCD_CH_ZERO && i_rx_data <= `PSCD_CH_NINE);

	// Letter and index form a known command
	always_comb begin
		case (cmd_reg)
			`PSCD_CH_A: cmd_ok = (v1_reg <= `PSCD_MAX_A);
			`PSCD_CH_B: cmd_ok = (v1_reg <= `PSCD_MAX_B);
			`PSCD_CH_C: cmd_ok = (v1_reg <= `PSCD_MAX_C);
			`PSCD_CH_E: cmd_ok = (v1_reg == 32'h0);
			`PSCD_CH_F: cmd_ok = (v1_reg <= `PSCD_MAX_F);
			`PSCD_CH_G: cmd_ok = (v1_reg <= `PSCD_MAX_G);
			default: cmd_ok = 1'b0;
		endcase
	end

	// Totalizer selected by the command index
	always_comb begin
		case (v1_reg[2:0])
			3'h0: tot_value = i_total_prod_vol;
			3'h1: tot_value = i_total_prod_cyc;
			3'h2: tot_value = i_last_fluid_vol;
			3'h3: tot_value = i_last_prod_vol;
			3'h4: tot_value = i_total_fluid_cyc;
			3'h5: tot_value = i_total_ref_cyc;
			default: tot_value = i_total_load_cyc;
		endcase
	end

	// ----------------------------------------------------------------
	// Command parsing, execution and response
	// ----------------------------------------------------------------
	// Number fed to the converter depends on the field being opened
	assign conv_value = (state_reg == ST_SEND_CMD) ? v1_reg :
		(state_reg == ST_SEND_SEP1) ? resp_reg : code_reg;
	assign conv_take = conv_valid && can_load &&
		(state_reg == ST_SEND_V1 || state_reg == ST_SEND_V2 || state_reg == ST_SEND_V3);

	// Next values of the command sequencer
	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		v1_next = v1_reg;
		v2_next = v2_reg;
		resp_next = resp_reg;
		code_next = code_reg;
		have_cmd_next = have_cmd_reg;
		comma_next = comma_reg;
		v2_seen_next = v2_seen_reg;
		alpha2_next = alpha2_reg;
		bad_next = bad_reg;
		empty_next = empty_reg;
		err_next = err_reg;
		tx_valid_next = tx_valid_reg && !i_tx_ready;
		tx_data_next = tx_data_reg;
		param_next = param_reg;
		clr_next = 5'h0;
		op_set = 16'h0;
		conv_start = 1'b0;
		case (state_reg)
			ST_RECV: begin
				if (rx_take) begin
					if (i_rx_data == `PSCD_CH_CR) begin
						state_next = ST_EXEC;
					end else if (is_alpha) begin
						if (!have_cmd_reg) begin
							cmd_next = i_rx_data;
							have_cmd_next = 1'b1;
						end else begin
							alpha2_next = 1'b1;
						end
					end else if (!have_cmd_reg) begin
						bad_next = 1'b1;
					end else if (is_digit && !comma_reg) begin
						v1_next = {v1_reg[28:0], 3'h0} + {v1_reg[30:0], 1'b0} +
							{28'h0, i_rx_data[3:0]};
					end else if (is_digit) begin
						v2_next = {v2_reg[28:0], 3'h0} + {v2_reg[30:0], 1'b0} +
							{28'h0, i_rx_data[3:0]};
						v2_seen_next = 1'b1;
					end else if (i_rx_data == `PSCD_CH_COMMA) begin
						v2_seen_next = v2_seen_reg || comma_reg;
						comma_next = 1'b1;
					end else begin
						bad_next = 1'b1;
					end
				end
			end
			ST_EXEC: begin
				empty_next = !have_cmd_reg && !bad_reg;
				err_next = bad_reg || (have_cmd_reg && !alpha2_reg && !cmd_ok);
				code_next = alpha2_reg ? `PSCD_WARN_SECOND_CMD : `PSCD_ERR_BAD_CMD;
				state_next = ST_SETTLE;
				if (have_cmd_reg && !bad_reg && !alpha2_reg && cmd_ok) begin
					case (cmd_reg)
						`PSCD_CH_A: begin
							if (v2_seen_reg) begin
								param_next[v1_reg[1:0]] = v2_reg[15:0];
							end
						end
						`PSCD_CH_B: op_set[v1_reg[0] ? `PSCD_BIT_FLUID : `PSCD_BIT_PROD] = 1'b1;
						`PSCD_CH_C: begin
							case (v1_reg[1:0])
								2'h0: op_set[`PSCD_BIT_CLR_FAULT] = 1'b1;
								2'h1: op_set[`PSCD_BIT_CLR_ALERT] = 1'b1;
								default: op_set[`PSCD_BIT_NEXT_OP] = 1'b1;
							endcase
						end
						`PSCD_CH_E: op_set[`PSCD_BIT_STOP] = 1'b1;
						`PSCD_CH_F: begin
							case (v1_reg[1:0])
								2'h0: op_set[`PSCD_BIT_REF] = 1'b1;
								2'h1: op_set[`PSCD_BIT_REF_UNSTICK] = 1'b1;
								default: op_set[`PSCD_BIT_REF_TORQUE] = 1'b1;
							endcase
						end
						default: begin
							if (v2_seen_reg && v2_reg == 32'h0 && v1_reg <= `PSCD_MAX_G_CLR) begin
								clr_next[v1_reg[2:0]] = 1'b1;
							end
						end
					endcase
				end
			end
			ST_SETTLE: begin
				state_next = ST_SAMPLE;
			end
			ST_SAMPLE: begin
				// Values are taken only after writes and clears have landed
				if (alpha2_reg) begin
					resp_next = 32'h0;
				end else if (cmd_reg == `PSCD_CH_A) begin
					resp_next = {16'h0, param_reg[v1_reg[1:0]]};
				end else if (cmd_reg == `PSCD_CH_G) begin
					resp_next = tot_value;
				end else begin
					resp_next = v2_reg;
				end
				if (err_reg) begin
					resp_next = 32'h0;
				end else if (!alpha2_reg) begin
					code_next = {16'h0, i_status_code};
				end
				state_next = ST_SEND_CMD;
			end
			ST_SEND_CMD: begin
				if (can_load) begin
					tx_valid_next = 1'b1;
					if (empty_reg) begin
						tx_data_next = `PSCD_CH_CR;
						state_next = ST_RECV;
					end else if (err_reg) begin
						tx_data_next = `PSCD_CH_ERR;
						state_next = ST_SEND_SEP1;
					end else begin
						tx_data_next = cmd_reg;
						conv_start = 1'b1;
						state_next = ST_SEND_V1;
					end
				end
			end
			ST_SEND_SEP1, ST_SEND_SEP2: begin
				if (can_load) begin
					tx_valid_next = 1'b1;
					tx_data_next = `PSCD_CH_COMMA;
					conv_start = 1'b1;
					state_next = (state_reg == ST_SEND_SEP1) ? ST_SEND_V2 : ST_SEND_V3;
				end
			end
			ST_SEND_V1, ST_SEND_V2, ST_SEND_V3: begin
				if (conv_take) begin
					tx_valid_next = 1'b1;
					tx_data_next = conv_char;
					if (conv_last) begin
						state_next = (state_reg == ST_SEND_V1) ? ST_SEND_SEP1 :
							(state_reg == ST_SEND_V2) ? ST_SEND_SEP2 : ST_SEND_CR;
					end
				end
			end
			ST_SEND_CR: begin
				if (can_load) begin
					tx_valid_next = 1'b1;
					tx_data_next = `PSCD_CH_CR;
					state_next = ST_RECV;
				end
			end
			default: begin
				state_next = ST_RECV;
			end
		endcase
		// A fresh command starts from a clean parse
		if (state_reg != ST_RECV && state_next == ST_RECV) begin
			v1_next = 32'h0;
			v2_next = 32'h0;
			have_cmd_next = 1'b0;
			comma_next = 1'b0;
			v2_seen_next = 1'b0;
			alpha2_next = 1'b0;
			bad_next = 1'b0;
		end
		rx_ready_next = (state_next == ST_RECV);
	end

	// Command sequencer registers
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= ST_RECV;
			cmd_reg <= 8'h0;
			v1_reg <= 32'h0;
			v2_reg <= 32'h0;
			resp_reg <= 32'h0;
			code_reg <= 32'h0;
			have_cmd_reg <= 1'b0;
			comma_reg <= 1'b0;
			v2_seen_reg <= 1'b0;
			alpha2_reg <= 1'b0;
			bad_reg <= 1'b0;
			empty_reg <= 1'b0;
			err_reg <= 1'b0;
			rx_ready_reg <= 1'b1;
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 8'h0;
			param_reg <= '{`PSCD_PARAM_RST, `PSCD_PARAM_RST, `PSCD_PARAM_RST, `PSCD_PARAM_RST};
			clr_reg <= 5'h0;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			v1_reg <= v1_next;
			v2_reg <= v2_next;
			resp_reg <= resp_next;
			code_reg <= code_next;
			have_cmd_reg <= have_cmd_next;
			comma_reg <= comma_next;
			v2_seen_reg <= v2_seen_next;
			alpha2_reg <= alpha2_next;
			bad_reg <= bad_next;
			empty_reg <= empty_next;
			err_reg <= err_next;
			rx_ready_reg <= rx_ready_next;
			tx_valid_reg <= tx_valid_next;
			tx_data_reg <= tx_data_next;
			param_reg <= param_next;
			clr_reg <= clr_next;
		end
	end

	// ----------------------------------------------------------------
	// Operation requests and stop completion
	// ----------------------------------------------------------------
	// Prime and agitate runs must reach their rest position first
	assign stop_ok = i_prime_mode ? i_piston_at_stop :
		(i_agitate_mode ? i_fluid_at_start : 1'b1);

	// Next request word; a new set wins over a same-cycle acknowledge
	always_comb begin
		op_next = (op_reg & ~i_op_ack) | op_set;
		stop_pend_next = op_set[`PSCD_BIT_STOP] || (stop_pend_reg && !stop_ok);
		op_end_next = stop_pend_reg && stop_ok;
	end

	// Request word registers
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			op_reg <= 16'h0;
			stop_pend_reg <= 1'b0;
			op_end_reg <= 1'b0;
		end else begin
			op_reg <= op_next;
			stop_pend_reg <= stop_pend_next;
			op_end_reg <= op_end_next;
		end
	end

	// Decimal digit source for the numeric fields
	pscd_dec_conv u_conv (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_start(conv_start),
		.i_value(conv_value),
		.i_take(conv_take),
		.o_valid(conv_valid),
		.o_char(conv_char),
		.o_last(conv_last)
	);

	// Outputs straight from registers
	assign o_rx_ready = rx_ready_reg;
	assign o_tx_valid = tx_valid_reg;
	assign o_tx_data = tx_data_reg;
	assign o_op_ctrl = op_reg;
	assign o_op_end = op_end_reg;
	assign o_total_clr = clr_reg;
	assign o_load_mode = param_reg[0];
	assign o_chamber_mode = param_reg[1];
	assign o_autotrig_mode = param_reg[2];
	assign o_autotrig_count = param_reg[3];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_exec_ok(logic [7:0] c, logic [31:0] n);
		state_reg == ST_EXEC && have_cmd_reg && !bad_reg && !alpha2_reg && cmd_reg == c && v1_reg == n;
	endsequence

	sequence s_stop_held;
		stop_pend_reg && !stop_ok;
	endsequence

	a_load_write: assert property (s_exec_ok(`PSCD_CH_A, 32'h0) ##0 v2_seen_reg |=>
		o_load_mode == $past(v2_reg[15:0])) else $error("load mode not written");
	a_count_write: assert property (s_exec_ok(`PSCD_CH_A, 32'h3) ##0 v2_seen_reg |=>
		o_autotrig_count == $past(v2_reg[15:0])) else $error("count not written");
	a_prod_start: assert property (s_exec_ok(`PSCD_CH_B, 32'h0) |=> o_op_ctrl[2])
		else $error("production request missing");
	a_clr_fault: assert property (s_exec_ok(`PSCD_CH_C, 32'h0) |=> o_op_ctrl[5])
		else $error("fault clear request missing");
	a_stop_req: assert property (s_exec_ok(`PSCD_CH_E, 32'h0) |=>
		o_op_ctrl[1] && stop_pend_reg) else $error("stop request missing");
	a_prime_hold: assert property (s_stop_held ##0 i_prime_mode |=> !o_op_end)
		else $error("prime stop ended early");
	a_agit_hold: assert property (s_stop_held ##0 i_agitate_mode |=> !o_op_end)
		else $error("agitate stop ended early");
	a_g0_clear: assert property (s_exec_ok(`PSCD_CH_G, 32'h0) ##0 v2_seen_reg &&
		v2_reg == 32'h0 |=> o_total_clr == 5'h01 ##1 o_total_clr == 5'h00)
		else $error("g0 clear pulse wrong");
	a_cr_ends: assert property (state_reg == ST_RECV && rx_take && i_rx_data == `PSCD_CH_CR
		|=> state_reg == ST_EXEC ##1 !o_rx_ready) else $error("command not closed by CR");
	a_warn_void: assert property (state_reg == ST_EXEC && alpha2_reg |=>
		o_op_ctrl == ($past(o_op_ctrl) & ~$past(i_op_ack)) ##2 code_reg == `PSCD_WARN_SECOND_CMD)
		else $error("voided command acted");
	a_status_code: assert property (state_reg == ST_SAMPLE && !err_reg && !alpha2_reg |=>
		code_reg == {16'h0, $past(i_status_code)}) else $error("status code not sent");
	a_req_hold: assert property (o_op_ctrl[4] && !i_op_ack[4] |=> o_op_ctrl[4])
		else $error("request dropped without acknowledge");
	a_req_clear: assert property (o_op_ctrl[4] && i_op_ack[4] && op_set[4] == 1'b0
		|=> !o_op_ctrl[4]) else $error("acknowledged request not cleared");

endmodule // pscd_decoder

//--- tb/pscd_host.sv
// Host terminal model: sends command strings, collects the response
`timescale 1ns/1ps
module pscd_host (
	input wire logic i_core_clk,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	input wire logic i_rx_ready,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	output logic o_tx_ready
);
	string rsp_buf = "";
	bit slow = 1'b0;

	// Idle link at time zero
	initial begin
		o_rx_valid = 1'b0;
		o_rx_data = 8'h00;
		o_tx_ready = 1'b1;
	end

	// Collect response bytes as they leave the decoder
	always @(posedge i_core_clk) begin
		if (i_tx_valid && o_tx_ready) begin
			rsp_buf = {rsp_buf, string'(i_tx_data)};
		end
	end

	// A slow host takes a byte only every other cycle
	always @(negedge i_core_clk) begin
		o_tx_ready <= slow ? !o_tx_ready : 1'b1;
	end

	// Send one command ended by CR, then wait for the response CR
	task automatic xfer(input string cmd, output string rsp);
		string s;
		int n;
		s = {cmd, "\r"};
		rsp_buf = "";
		for (int i = 0; i < s.len(); i++) begin
			@(negedge i_core_clk);
			o_rx_valid = 1'b1;
			o_rx_data = s[i];
			do @(posedge i_core_clk); while (i_rx_ready !== 1'b1);
		end
		@(negedge i_core_clk);
		o_rx_valid = 1'b0;
		o_rx_data = ~o_rx_data;
		n = 0;
		while ((rsp_buf.len() == 0 || rsp_buf[rsp_buf.len() - 1] != 8'h0d) && n < 3000) begin
			@(negedge i_core_clk);
			n++;
		end
		rsp = rsp_buf;
	endtask
endmodule // pscd_host

//--- tb/testbench.sv
// Self-checking testbench for the serial command decoder
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic rx_valid, rx_ready, tx_valid, tx_ready, op_end;
	logic prime = 1'b0, agit = 1'b0, at_stop = 1'b0, at_start = 1'b0;
	logic [7:0] rx_data, tx_data;
	logic [15:0] op_ctrl, op_ack = 16'h0000, status = 16'h0000;
	logic [15:0] prm [4];
	logic [4:0] tot_clr;
	logic [31:0] tot [7];
	int err_count = 0;
	int samples_checked = 0;
	int ends = 0;
	int clr_cnt = 0;
	string rsp;

	pscd_decoder DUT (.i_core_clk(clk), .i_rstn(rstn), .i_rx_valid(rx_valid),
		.i_rx_data(rx_data), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid),
		.o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_op_ctrl(op_ctrl), .i_op_ack(op_ack),
		.o_op_end(op_end), .i_prime_mode(prime), .i_agitate_mode(agit),
		.i_piston_at_stop(at_stop), .i_fluid_at_start(at_start), .i_status_code(status),
		.o_load_mode(prm[0]), .o_chamber_mode(prm[1]), .o_autotrig_mode(prm[2]),
		.o_autotrig_count(prm[3]), .o_total_clr(tot_clr), .i_total_prod_vol(tot[0]),
		.i_total_prod_cyc(tot[1]), .i_last_fluid_vol(tot[2]), .i_last_prod_vol(tot[3]),
		.i_total_fluid_cyc(tot[4]), .i_total_ref_cyc(tot[5]), .i_total_load_cyc(tot[6]));

	pscd_host host (.i_core_clk(clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
		.i_rx_ready(rx_ready), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
		.o_tx_ready(tx_ready));

	// 10 MHz clock
	initial begin
		forever #50 clk = ~clk;
	end

	// Totalizers clear on the edge after their pulse; count stop ends and clears
	always @(posedge clk) begin
		for (int k = 0; k < 5; k++) begin
			if (tot_clr[k]) tot[k] <= 32'h0;
		end
		if (op_end === 1'b1) ends++;
		clr_cnt += $countones(tot_clr);
	end

	// ----------------------------------------------------------------
	// Compare and closing tasks
	// ----------------------------------------------------------------
	task automatic chk_s(input string got, input string exp);
		samples_checked++;
		if (got != exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Write each parameter, then read one back with a status code present
	task automatic t_params();
		for (int i = 0; i < 4; i++) begin
			host.xfer($sformatf("a%0d,%0d", i, 300 + i), rsp);
			chk_s(rsp, $sformatf("a%0d,%0d,0\r", i, 300 + i));
			chk_v(prm[i], 300 + i);
		end
		status = 16'h0007;
		host.xfer("a2", rsp);
		chk_s(rsp, "a2,302,7\r");
		status = 16'h0000;
		host.xfer("a0,", rsp);
		chk_s(rsp, "a0,300,0\r");
		chk_v(prm[0], 300);
	endtask

	// Every request command sets its bit until acknowledged
	task automatic t_ops();
		string c [13] = '{"b", "b0", "b1", "c", "c0", "c1", "c2", "e", "e0", "f", "f0", "f1", "f2"};
		int b [13] = '{2, 2, 3, 5, 5, 6, 13, 1, 1, 4, 4, 11, 12};
		string ex;
		for (int i = 0; i < 13; i++) begin
			host.xfer(c[i], rsp);
			// A missing index is echoed as zero, a given one as it was sent
			ex = c[i];
			if (ex.len() == 1) ex = {ex, "0"};
			chk_s(rsp, $sformatf("%s,0,0\r", ex));
			chk_v(op_ctrl, 32'h1 << b[i]);
			op_ack = op_ctrl;
			@(negedge clk);
			op_ack = 16'h0000;
			@(negedge clk);
			chk_v(op_ctrl, 32'h0);
		end
	endtask

	// Stop in prime or agitate mode waits for the rest position
	task automatic t_stop(input logic md);
		int n0;
		n0 = ends;
		prime = !md;
		agit = md;
		host.xfer("e", rsp);
		repeat (20) @(negedge clk);
		chk_v(ends - n0, 0);
		at_stop = !md;
		at_start = md;
		repeat (10) @(negedge clk);
		chk_v(ends - n0, 1);
		{prime, agit, at_stop, at_start} = 4'h0;
		op_ack = 16'h0002;
		@(negedge clk);
		op_ack = 16'h0000;
	endtask

	// Read each totalizer, then send its clear; only the five that can be cleared go to zero
	task automatic t_totals();
		for (int i = 0; i < 7; i++) begin
			host.xfer($sformatf("g%0d", i), rsp);
			chk_s(rsp, $sformatf("g%0d,%0d,0\r", i, 1000 + 37 * i));
			host.xfer($sformatf("g%0d,0", i), rsp);
			chk_s(rsp, $sformatf("g%0d,%0d,0\r", i, (i < 5) ? 0 : 1000 + 37 * i));
		end
		chk_v(clr_cnt, 5);
	endtask

	// Faulty commands through a slow host; nothing may take effect
	task automatic t_errors();
		string c [5] = '{"a1,9x", "z", "", "a9", "B"};
		string e [5] = '{"a1,0,1\r", "?,0,2\r", "\r", "?,0,2\r", "?,0,2\r"};
		for (int i = 0; i < 5; i++) begin
			host.xfer(c[i], rsp);
			chk_s(rsp, e[i]);
		end
		chk_v(prm[1], 301);
		chk_v(op_ctrl, 32'h0);
	endtask

	// Main sequence
	initial begin
		for (int i = 0; i < 7; i++) tot[i] = 1000 + 37 * i;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		t_params();
		t_ops();
		t_stop(1'b0);
		t_stop(1'b1);
		t_totals();
		host.slow = 1'b1;
		t_errors();
		print_verdict();
	end

	// Watchdog: about 6k cycles expected, cut off at 50k
	initial begin
		#5000000;
		err_count++;
		print_verdict();
	end
endmodule // testbench
